/* common/sms_pkg.sv */
// Constants, register map and state layout of the serial peripheral core
// How it works
// RULE1: Role bit picks master when set, slave when clear; any change forces idle.
// RULE2: Enable clear holds the core idle and resets status flags; set claims pins.
// RULE3: General interrupt enable passes done and mode-fault flags onto the request.
// RULE4: Transmit interrupt enable passes the transmit-empty flag onto the request.
// RULE5: Polarity bit sets serial clock idle level: zero low, one high.
// RULE6: Phase zero samples on odd clock edges, phase one on even edges.
// RULE7: As master, changing polarity or phase aborts the transfer and returns idle.
// RULE8: Both ends must share the same clock polarity to exchange data.
// RULE9: In wait mode with stop-in-wait clear, operation equals run mode.
// RULE10: Wait with stop-in-wait set halts clock generation; master pauses, then resumes.
// RULE11: Stop mode makes the core inactive; a master transfer pauses and resumes later.
// RULE12: As slave, shifting continues in low-power modes to stay in step.
// RULE13: Reserved bits read as zero and ignore writes.
// RULE14: Six registers at offsets zero to five above a system base.
// RULE15: Double-buffered data register, eight or sixteen bits, from two bytes.
// RULE16: Master drives master-out and samples master-in; slave does the reverse.
// RULE17: Master drives the serial clock; slave takes it from the external master.
// RULE18: Select pin is an output as master, an input driven externally as slave.
// RULE19: As master, select is an output only with fault enable and output enable set.
// RULE20: Width bit zero uses the low byte only; one uses both bytes.
// RULE21: Bit-order bit picks MSB or LSB first; register bit positions unchanged.
// RULE22: Master clock rate comes from prescaler and divider fields of the baud register.
package sms_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [2:0] IDX_CR1 = 3'h0;
  localparam logic [2:0] IDX_CR2 = 3'h1;
  localparam logic [2:0] IDX_BR = 3'h2;
  localparam logic [2:0] IDX_SR = 3'h3;
  localparam logic [2:0] IDX_DH = 3'h4;
  localparam logic [2:0] IDX_DL = 3'h5;
  localparam logic [2:0] IDX_RSV6 = 3'h6;
  localparam logic [2:0] IDX_RSV7 = 3'h7;

  // control_one fields
  localparam int B_IRQ_ENABLE_GENERAL = 7;
  localparam int B_SYSTEM_ENABLE_BIT = 6;
  localparam int B_TX_EMPTY_IRQ_ENABLE = 5;
  localparam int B_MASTER_ROLE_SELECT = 4;
  localparam int B_CLOCK_POLARITY = 3;
  localparam int B_CLOCK_PHASE = 2;
  localparam int B_SELECT_OUTPUT_ENABLE = 1;
  localparam int B_LOW_BIT_FIRST = 0;

  // control_two fields
  localparam int B_TRANSFER_WIDTH_SEL = 6;
  localparam int B_FAULT_DETECT_ENABLE = 4;
  localparam int B_BIDIR_OUTPUT_ENABLE = 3;
  localparam int B_STOP_IN_WAIT = 1;
  localparam int B_PIN_CONTROL_ZERO = 0;

  // baud_select fields
  localparam int BR_PS_HI = 6;
  localparam int BR_PS_LO = 4;
  localparam int BR_DV_HI = 2;
  localparam int BR_DV_LO = 0;

  // Values after reset and implemented-bit masks
  localparam logic [7:0] CR1_RST = 8'h04;
  localparam logic [7:0] CR2_RST = 8'h00;
  localparam logic [7:0] BR_RST = 8'h00;
  localparam logic [7:0] CR2_MASK = 8'h5b;
  localparam logic [7:0] BR_MASK = 8'h77;

  // Synchroniser lanes
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS = 3;

  // Edge counts for a whole transfer
  localparam logic [5:0] EDGES_8 = 6'h10;
  localparam logic [5:0] EDGES_16 = 6'h20;

  typedef struct packed {
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] br;
    logic transfer_done_flag;
    logic tx_empty_flag;
    logic mode_fault_flag;
    logic done_arm;
    logic fault_arm;
    logic [15:0] tx_buf;
    logic [15:0] rx_buf;
    logic [15:0] shifter;
    logic tx_full;
    logic busy;
    logic samp;
    logic [5:0] edge_cnt;
    logic [10:0] div_cnt;
    logic sck_lvl;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sck_prev;
    logic ack;
    logic [7:0] rdata;
    logic irq;
    logic sck_o;
    logic sck_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
    logic ss_o;
    logic ss_oe_n;
  } sms_state_t;

  localparam sms_state_t STATE_RST = '{
    cr1: CR1_RST, cr2: CR2_RST, br: BR_RST, tx_empty_flag: 1'b1,
    sck_oe_n: 1'b1, mosi_oe_n: 1'b1, miso_oe_n: 1'b1, ss_oe_n: 1'b1, ss_o: 1'b1,
    default: '0
  };

endpackage

/* rtl/sms_core.sv */
// Serial peripheral core, master or slave, with a Wishbone register slave
`timescale 1ns/1ps
module sms_core (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Processor power state
  input wire logic i_wait_mode,
  input wire logic i_stop_mode,
  // Interrupt request
  output logic o_irq,
  // Serial clock pin
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  // Master-out pin
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  // Master-in pin
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe_n,
  // Slave-select pin, active low
  input wire logic i_ss_n,
  output logic o_ss_n,
  output logic o_ss_oe_n
);

  sms_pkg::sms_state_t st;
  sms_pkg::sms_state_t nx;

  logic req;
  logic wr;
  logic rd;
  logic mapped;
  logic [2:0] idx;
  logic [7:0] wb;
  logic dl_wr;
  logic master;
  logic en;
  logic clock_polarity;
  logic clock_phase;
  logic w16;
  logic lsb;
  logic pin_control_zero;
  logic pause;
  logic sel;
  logic din;
  logic tick;
  logic edge_ev;
  logic fault_ev;
  logic abort;
  logic [7:0] ch1;
  logic [7:0] ch2;
  logic [5:0] k;
  logic [5:0] last;
  logic [10:0] half;

  // Next bit into the shifter; register bit positions stay fixed for either order
  function automatic logic [15:0] shift_in(input logic [15:0] s, input logic b,
                                           input logic w, input logic l);
    if (!l) begin
      return {s[14:0], b};
    end else if (w) begin
      return {b, s[15:1]};
    end else begin
      return {s[15:8], b, s[7:1]};
    end
  endfunction

  function automatic logic out_bit(input logic [15:0] s, input logic w, input logic l);
    if (l) begin
      return s[0];
    end else begin
      return w ? s[15] : s[7];
    end
  endfunction

  // Bus decode
  assign req = i_wb_cyc && i_wb_stb && !st.ack;
  assign mapped = (i_wb_adr[7:5] == 3'h0);
  assign idx = i_wb_adr[4:2];
  assign wb = i_wb_dat[7:0];
  assign wr = req && i_wb_we && i_wb_sel[0] && mapped;
  assign rd = req && !i_wb_we;
  assign dl_wr = wr && (idx == sms_pkg::IDX_DL);

  // Configuration fields
  assign master = st.cr1[sms_pkg::B_MASTER_ROLE_SELECT];
  assign en = st.cr1[sms_pkg::B_SYSTEM_ENABLE_BIT];
  // Far end must use the same polarity; nothing here can detect a mismatch
  assign clock_polarity = st.cr1[sms_pkg::B_CLOCK_POLARITY]; // RULE8
  assign clock_phase = st.cr1[sms_pkg::B_CLOCK_PHASE];
  assign lsb = st.cr1[sms_pkg::B_LOW_BIT_FIRST];
  assign w16 = st.cr2[sms_pkg::B_TRANSFER_WIDTH_SEL];
  assign pin_control_zero = st.cr2[sms_pkg::B_PIN_CONTROL_ZERO];
  assign last = w16 ? sms_pkg::EDGES_16 : sms_pkg::EDGES_8; // RULE20

  // Low-power gating applies to the master's clock generation only
  assign pause = (i_wait_mode && st.cr2[sms_pkg::B_STOP_IN_WAIT]) || i_stop_mode; // RULE9 RULE10 RULE11

  // Half period of the serial clock in system clocks
  assign half = 11'({1'b0, st.br[sms_pkg::BR_PS_HI:sms_pkg::BR_PS_LO]} + 4'h1)
                << st.br[sms_pkg::BR_DV_HI:sms_pkg::BR_DV_LO]; // RULE22

  // Synchronised pin views
  assign sel = !st.sync2[sms_pkg::PIN_SS]; // RULE18
  assign din = master ? (pin_control_zero ? st.sync2[sms_pkg::PIN_MOSI] : st.sync2[sms_pkg::PIN_MISO])
                      : (pin_control_zero ? st.sync2[sms_pkg::PIN_MISO] : st.sync2[sms_pkg::PIN_MOSI]); // RULE16

  // Serial clock edges: generated as master, detected on the pin as slave
  assign tick = st.busy && !pause && (st.div_cnt == half - 11'h1);
  assign edge_ev = master ? tick // RULE17
                          : (sel && st.busy && (st.sync2[sms_pkg::PIN_SCK] != st.sck_prev));
  assign k = st.edge_cnt + 6'h1;

  // Mode fault: select pulled low by another master while select is an input
  assign fault_ev = en && master && st.cr2[sms_pkg::B_FAULT_DETECT_ENABLE]
                    && !st.cr1[sms_pkg::B_SELECT_OUTPUT_ENABLE] && sel;

  // Configuration changes that force the shifter idle
  assign ch1 = (wr && idx == sms_pkg::IDX_CR1) ? (wb ^ st.cr1) : 8'h00;
  assign ch2 = (wr && idx == sms_pkg::IDX_CR2) ? ((wb & sms_pkg::CR2_MASK) ^ st.cr2) : 8'h00;
  assign abort = !en // RULE2
    || ch1[sms_pkg::B_MASTER_ROLE_SELECT] // RULE1
    || (master && (ch1[sms_pkg::B_CLOCK_POLARITY] || ch1[sms_pkg::B_CLOCK_PHASE])) // RULE7
    || (master && (ch1[sms_pkg::B_SELECT_OUTPUT_ENABLE] || ch1[sms_pkg::B_LOW_BIT_FIRST]
        || ch2[sms_pkg::B_TRANSFER_WIDTH_SEL] || ch2[sms_pkg::B_FAULT_DETECT_ENABLE]
        || ch2[sms_pkg::B_PIN_CONTROL_ZERO]
        || (pin_control_zero && ch2[sms_pkg::B_BIDIR_OUTPUT_ENABLE])))
    || fault_ev;

  always_comb begin
    nx = st;

    // Two-stage synchronisers; only the second stage feeds logic
    nx.sync1 = {i_ss_n, i_miso, i_mosi, i_sck};
    nx.sync2 = st.sync1;
    nx.sck_prev = st.sync2[sms_pkg::PIN_SCK];

    // Register writes
    nx.ack = req;
    if (wr) begin
      case (idx)
        sms_pkg::IDX_CR1: begin
          nx.cr1 = wb;
          if (st.fault_arm) begin
            nx.mode_fault_flag = 1'b0;
            nx.fault_arm = 1'b0;
          end
        end
        sms_pkg::IDX_CR2: nx.cr2 = wb & sms_pkg::CR2_MASK; // RULE13
        sms_pkg::IDX_BR: nx.br = wb & sms_pkg::BR_MASK; // RULE13
        sms_pkg::IDX_DH: nx.tx_buf[15:8] = wb; // RULE15
        sms_pkg::IDX_DL: begin
          nx.tx_buf[7:0] = wb; // RULE15
          nx.tx_full = 1'b1;
          nx.tx_empty_flag = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Register reads, with the flag-clearing side effects
    if (rd) begin
      nx.rdata = 8'h00; // RULE13
      if (mapped) begin
        case (idx) // RULE14
          sms_pkg::IDX_CR1: nx.rdata = st.cr1;
          sms_pkg::IDX_CR2: nx.rdata = st.cr2;
          sms_pkg::IDX_BR: nx.rdata = st.br;
          sms_pkg::IDX_SR: begin
            nx.rdata = {st.transfer_done_flag, 1'b0, st.tx_empty_flag,
                        st.mode_fault_flag, 4'h0};
            nx.done_arm = st.transfer_done_flag;
            nx.fault_arm = st.mode_fault_flag;
          end
          sms_pkg::IDX_DH: nx.rdata = st.rx_buf[15:8];
          sms_pkg::IDX_DL: begin
            nx.rdata = st.rx_buf[7:0];
            if (st.done_arm) begin
              nx.transfer_done_flag = 1'b0;
              nx.done_arm = 1'b0;
            end
          end
          default: nx.rdata = 8'h00;
        endcase
      end
    end

    // Master: load the shifter from the transmit buffer
    if (master && en && !st.busy && st.tx_full && !pause && !dl_wr && !abort) begin
      nx.busy = 1'b1;
      nx.shifter = st.tx_buf;
      nx.tx_full = 1'b0;
      nx.tx_empty_flag = 1'b1;
      nx.div_cnt = 11'h000;
      nx.edge_cnt = 6'h00;
      nx.sck_lvl = 1'b0;
    end

    // Master: half-period divider, frozen while paused
    if (master && st.busy && !pause) begin // RULE10 RULE11
      nx.div_cnt = tick ? 11'h000 : st.div_cnt + 11'h001;
    end

    // Slave: armed whenever selected; low power does not stop it
    if (!master && en) begin // RULE12
      if (!sel) begin
        nx.busy = 1'b0;
        nx.edge_cnt = 6'h00;
      end else if (!st.busy) begin
        nx.busy = 1'b1;
        nx.edge_cnt = 6'h00;
      end
      // Until the first edge the outgoing word follows late buffer writes
      if (st.busy && st.edge_cnt == 6'h00) begin
        nx.shifter = st.tx_buf;
      end
      if (edge_ev && k == 6'h01 && st.tx_full && !dl_wr) begin
        nx.tx_full = 1'b0;
        nx.tx_empty_flag = 1'b1;
      end
    end

    // Serial clock edge handling shared by both roles
    if (edge_ev) begin
      nx.edge_cnt = k;
      if (master) begin
        nx.sck_lvl = !st.sck_lvl;
      end
      if (k == last) begin // RULE20
        nx.rx_buf = shift_in(st.shifter, clock_phase ? din : st.samp, w16, lsb); // RULE21
        nx.transfer_done_flag = 1'b1;
        nx.busy = 1'b0;
        nx.edge_cnt = 6'h00;
        nx.sck_lvl = 1'b0;
      end else if (k[0] ^ clock_phase) begin // RULE6
        nx.samp = din;
      end else if (k != 6'h01) begin
        nx.shifter = shift_in(st.shifter, st.samp, w16, lsb); // RULE21
      end
    end

    // Mode fault drops the role to slave
    if (fault_ev) begin
      nx.mode_fault_flag = 1'b1;
      nx.cr1[sms_pkg::B_MASTER_ROLE_SELECT] = 1'b0;
    end

    if (abort) begin // RULE1 RULE7
      nx.busy = 1'b0;
      nx.edge_cnt = 6'h00;
      nx.div_cnt = 11'h000;
      nx.sck_lvl = 1'b0;
    end

    if (!en) begin // RULE2
      nx.transfer_done_flag = 1'b0;
      nx.mode_fault_flag = 1'b0;
      nx.tx_empty_flag = 1'b1;
      nx.tx_full = 1'b0;
      nx.done_arm = 1'b0;
      nx.fault_arm = 1'b0;
    end

    // Interrupt request
    nx.irq = en && ((st.cr1[sms_pkg::B_IRQ_ENABLE_GENERAL] // RULE3
                     && (st.transfer_done_flag || st.mode_fault_flag))
                    || (st.cr1[sms_pkg::B_TX_EMPTY_IRQ_ENABLE] && st.tx_empty_flag)); // RULE4

    // Pin drivers, registered; enables are low while driving
    nx.sck_o = clock_polarity ^ (master && en && st.sck_lvl); // RULE5
    nx.sck_oe_n = !(master && en); // RULE17
    nx.mosi_o = out_bit(st.shifter, w16, lsb);
    nx.mosi_oe_n = !(master && en && (!pin_control_zero || st.cr2[sms_pkg::B_BIDIR_OUTPUT_ENABLE])); // RULE16
    nx.miso_o = out_bit(st.shifter, w16, lsb);
    nx.miso_oe_n = !(!master && en && sel
                     && (!pin_control_zero || st.cr2[sms_pkg::B_BIDIR_OUTPUT_ENABLE])); // RULE16
    nx.ss_oe_n = !(master && en && st.cr2[sms_pkg::B_FAULT_DETECT_ENABLE]
                   && st.cr1[sms_pkg::B_SELECT_OUTPUT_ENABLE]); // RULE19
    // Select stays low one cycle past the last clock edge, so the far end
    // never sees that edge and the release in the same instant
    nx.ss_o = !(master && (st.busy || (!st.ss_o && (st.sck_o != clock_polarity)))); // RULE18
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st <= sms_pkg::STATE_RST;
    end else begin
      st <= nx;
    end
  end

  assign o_wb_dat = {24'h000000, st.rdata};
  assign o_wb_ack = st.ack;
  assign o_irq = st.irq;
  assign o_sck = st.sck_o;
  assign o_sck_oe_n = st.sck_oe_n;
  assign o_mosi = st.mosi_o;
  assign o_mosi_oe_n = st.mosi_oe_n;
  assign o_miso = st.miso_o;
  assign o_miso_oe_n = st.miso_oe_n;
  assign o_ss_n = st.ss_o;
  assign o_ss_oe_n = st.ss_oe_n;

  property p_role_idle;
    @(posedge i_sys_clk) disable iff (i_reset)
    (wr && idx == sms_pkg::IDX_CR1 && (wb[sms_pkg::B_MASTER_ROLE_SELECT] != master))
    |=> !st.busy;
  endproperty
  a_role_idle: assert property (p_role_idle) else $error("role change left shifter busy"); // RULE1

  property p_disable;
    @(posedge i_sys_clk) disable iff (i_reset)
    !en |=> (!st.transfer_done_flag && !st.mode_fault_flag && !st.busy && st.tx_empty_flag);
  endproperty
  a_disable: assert property (p_disable) else $error("disabled core kept state"); // RULE2

  property p_irq_general;
    @(posedge i_sys_clk) disable iff (i_reset)
    (en && st.cr1[sms_pkg::B_IRQ_ENABLE_GENERAL] && st.transfer_done_flag) |=> o_irq;
  endproperty
  a_irq_general: assert property (p_irq_general) else $error("done flag gave no irq"); // RULE3

  property p_irq_masked;
    @(posedge i_sys_clk) disable iff (i_reset)
    (!st.cr1[sms_pkg::B_IRQ_ENABLE_GENERAL] && !st.cr1[sms_pkg::B_TX_EMPTY_IRQ_ENABLE])
    |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with both enables clear"); // RULE4

  property p_idle_level;
    @(posedge i_sys_clk) disable iff (i_reset)
    (master && en && !st.busy && !st.sck_lvl) |=> (o_sck == $past(clock_polarity));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong"); // RULE5

  property p_phase_abort;
    @(posedge i_sys_clk) disable iff (i_reset)
    (master && st.busy && (ch1[sms_pkg::B_CLOCK_POLARITY] || ch1[sms_pkg::B_CLOCK_PHASE]))
    |=> (!st.busy && st.edge_cnt == 6'h00);
  endproperty
  a_phase_abort: assert property (p_phase_abort) else $error("format change did not abort"); // RULE7

  property p_master_pause;
    @(posedge i_sys_clk) disable iff (i_reset)
    (master && st.busy && pause && !abort) |=> (st.busy && $stable(st.edge_cnt)
                                                && $stable(st.sck_lvl));
  endproperty
  a_master_pause: assert property (p_master_pause) else $error("master moved while paused"); // RULE10

  property p_slave_runs;
    @(posedge i_sys_clk) disable iff (i_reset)
    (!master && !abort && pause && edge_ev && k != last && sel)
    |=> (st.edge_cnt == $past(st.edge_cnt) + 6'h01);
  endproperty
  a_slave_runs: assert property (p_slave_runs) else $error("slave stalled in low power"); // RULE12

  property p_rsvd_read;
    @(posedge i_sys_clk) disable iff (i_reset)
    (rd && mapped && (idx == sms_pkg::IDX_RSV6 || idx == sms_pkg::IDX_RSV7))
    |=> (o_wb_ack && st.rdata == 8'h00);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved word read nonzero"); // RULE13

  property p_cr1_read;
    @(posedge i_sys_clk) disable iff (i_reset)
    (rd && mapped && idx == sms_pkg::IDX_CR1) |=> (o_wb_ack && st.rdata == $past(st.cr1));
  endproperty
  a_cr1_read: assert property (p_cr1_read) else $error("control one read mismatch"); // RULE14

  property p_ss_input;
    @(posedge i_sys_clk) disable iff (i_reset)
    !(master && en && st.cr2[sms_pkg::B_FAULT_DETECT_ENABLE]
      && st.cr1[sms_pkg::B_SELECT_OUTPUT_ENABLE]) |=> o_ss_oe_n;
  endproperty
  a_ss_input: assert property (p_ss_input) else $error("select driven when not allowed"); // RULE19

endmodule

/* bench/sms_slave_model.sv */
// Behavioural serial slave that answers the core in master role
`timescale 1ns/1ps
module sms_slave_model (
  // Link pins
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  output logic o_miso,
  // Frame setup
  input wire logic i_clock_phase,
  input wire logic i_lsb,
  input wire logic i_w16,
  input wire logic [15:0] i_tx,
  output logic [15:0] o_rx
);
  int k;
  int n;
  function automatic int bit_at(int i);
    return i_lsb ? i : n - 1 - i;
  endfunction
  initial begin
    o_miso = 1'b0;
    o_rx = '0;
    k = 0;
    n = 8;
  end
  always @(negedge i_ss_n) begin
    k = 0;
    n = i_w16 ? 16 : 8;
    o_rx = '0;
    if (!i_clock_phase) o_miso = i_tx[bit_at(0)];
  end
  // Released line shows the inverse so a stale bit never passes for data
  always @(posedge i_ss_n) o_miso = ~o_miso;
  // Any level change counts as an edge, so the idle level needs no input
  always @(i_sck) begin
    if (!i_ss_n && k < 2 * n) begin
      k = k + 1;
      if ((k % 2 == 1) != i_clock_phase) o_rx[bit_at((k - 1) / 2)] = i_mosi;
      else if (k / 2 < n) o_miso = i_tx[bit_at(k / 2)];
    end
  end
endmodule

/* bench/sms_core_tb.sv */
// Self-checking bench for the serial peripheral core
`timescale 1ns/1ps
module sms_core_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic wait_m = 1'b0;
  logic stop_m = 1'b0;
  logic tb_sck = 1'b0;
  logic tb_mosi = 1'b0;
  logic tb_ss_n = 1'b1;
  logic [7:0] c1_r = 8'h00;
  logic [7:0] c2_r = 8'h00;
  logic [15:0] s_r = 16'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, o_irq, o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n;
  logic o_miso, o_miso_oe_n, o_ss_n, o_ss_oe_n, m_miso;
  logic [15:0] m_rx;
  logic [7:0] q;
  logic [7:0] ab [2] = '{8'h56, 8'h42};
  int error_cnt = 0;
  int compares = 0;
  int n;
  wire sck_w = o_sck_oe_n ? tb_sck : o_sck;
  wire mosi_w = o_mosi_oe_n ? tb_mosi : o_mosi;
  wire miso_w = o_miso_oe_n ? m_miso : o_miso;
  wire ss_w = o_ss_oe_n ? tb_ss_n : o_ss_n;

  always #20 clk = ~clk;

  sms_core sms_core_i (.i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_wait_mode(wait_m), .i_stop_mode(stop_m), .o_irq(o_irq),
    .i_sck(sck_w), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .i_mosi(mosi_w),
    .o_mosi(o_mosi), .o_mosi_oe_n(o_mosi_oe_n), .i_miso(miso_w), .o_miso(o_miso),
    .o_miso_oe_n(o_miso_oe_n), .i_ss_n(ss_w), .o_ss_n(o_ss_n), .o_ss_oe_n(o_ss_oe_n));

  sms_slave_model sms_slave_model_i (.i_sck(sck_w), .i_ss_n(ss_w), .i_mosi(mosi_w),
    .o_miso(m_miso), .i_clock_phase(c1_r[2]), .i_lsb(c1_r[0]), .i_w16(c2_r[6]), .i_tx(s_r),
    .o_rx(m_rx));

  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    // No cycle limit here: only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (o_wb_ack !== 1'b1);
    r = o_wb_dat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    check(r, e);
  endtask

  // Master transfer; p picks a pause: 1 wait, 2 stop
  task automatic mx(input logic [7:0] c1, input logic [7:0] c2, input logic [15:0] d,
      input logic [15:0] s, input int p);
    logic [7:0] r;
    logic v;
    int i;
    c1_r = c1;
    c2_r = c2;
    s_r = s;
    wr(8'h04, c2);
    wr(8'h00, c1);
    if (c2[6]) wr(8'h10, d[15:8]);
    wr(8'h14, d[7:0]);
    if (p != 0) begin
      repeat (20) @(posedge clk);
      if (p == 1) wait_m <= 1'b1;
      else stop_m <= 1'b1;
      repeat (2) @(posedge clk);
      v = o_sck;
      repeat (40) @(posedge clk);
      check(o_sck, v);
      check(o_ss_n, 1'b0);
      wait_m <= 1'b0;
      stop_m <= 1'b0;
    end
    i = 0;
    do begin
      wb(1'b0, 8'h0c, 8'h00, r);
      i++;
    end while (r[7] !== 1'b1 && i < 100);
    check(r[7], 1'b1);
    check(o_irq, 1'b0);
    check(o_sck, c1[3]);
    check(o_sck_oe_n, 1'b0);
    check(o_ss_oe_n, 1'b0);
    wb(1'b0, 8'h14, 8'h00, r);
    check(r, s[7:0]);
    if (c2[6]) begin
      wb(1'b0, 8'h10, 8'h00, r);
      check(r, s[15:8]);
    end
    check(m_rx, c2[6] ? d : {8'h00, d[7:0]});
  endtask

  // Slave frame at 320 ns per bit, mode 0, most significant bit first
  task automatic sx(input logic [7:0] t, output logic [7:0] r);
    tb_ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= t[i];
      repeat (4) @(posedge clk);
      tb_sck <= 1'b1;
      repeat (4) @(posedge clk);
      r[i] = o_miso;
      tb_sck <= 1'b0;
    end
    check(o_miso_oe_n, 1'b0);
    check(o_mosi_oe_n, 1'b1);
    check(o_sck_oe_n, 1'b1);
    check(o_ss_oe_n, 1'b1);
    repeat (8) @(posedge clk);
    tb_ss_n <= 1'b1;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 8'h04);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h0c, 8'h20);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h5b);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h77);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h20);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    rd(8'h1c, 8'h00);
    rd(8'he0, 8'h00);
    wr(8'h08, 8'h02);
    mx(8'h52, 8'h10, 16'h00c3, 16'h005a, 0);
    mx(8'h5e, 8'h10, 16'h0081, 16'h007e, 0);
    mx(8'h5b, 8'h10, 16'h0013, 16'h00c8, 0);
    mx(8'h56, 8'h50, 16'ha5c3, 16'h3c96, 0);
    mx(8'h53, 8'h52, 16'h1234, 16'h8001, 1);
    mx(8'h52, 8'h10, 16'h00f0, 16'h000f, 2);
    wait_m <= 1'b1;
    mx(8'h52, 8'h10, 16'h0066, 16'h0099, 0);
    wait_m <= 1'b0;
    // Mid-frame phase change, then mid-frame role change
    foreach (ab[i]) begin
      wr(8'h00, 8'h52);
      wr(8'h14, 8'h55);
      repeat (30) @(posedge clk);
      wr(8'h00, ab[i]);
      repeat (80) @(posedge clk);
      check(ss_w, 1'b1);
      rd(8'h0c, 8'h20);
    end
    wr(8'h00, 8'h72);
    repeat (2) @(posedge clk);
    check(o_irq, 1'b1);
    wr(8'h00, 8'hd2);
    repeat (2) @(posedge clk);
    check(o_irq, 1'b0);
    wr(8'h14, 8'h77);
    n = 0;
    while (o_irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(o_irq, 1'b1);
    wr(8'h00, 8'h12);
    wb(1'b0, 8'h0c, 8'h00, q);
    check(q[7], 1'b0);
    check(o_irq, 1'b0);
    check(o_sck_oe_n, 1'b1);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h14, 8'h3c);
    stop_m <= 1'b1;
    sx(8'h96, q);
    check(q, 8'h3c);
    rd(8'h14, 8'h96);
    stop_m <= 1'b0;
    summarize();
  end
endmodule
